// ===== pkg/dctm_cfg.svh
// How it works
// - Six count clock sources per timer.
// - Counter mode counts falling event pin edges.
// - Events up to quarter clock, two-cycle levels.
// - Each timer picks one of four modes.
// - Mode 0: high byte plus low five bits.
// - Mode 0 wrap sets flag, requests interrupt.
// - Count source bit selects event pin clock.
// - Sysclk select bit: system or prescaled clock.
// - Outside split mode, count only when run and gate allow.
// - Gate input level follows its polarity bit.
// - Run bit never clears or reloads count.
// - Mode 1 is mode 0 over sixteen bits.
// - Mode 2: low counts, high holds reload.
// - Mode 2 wrap flags and reloads low byte.
// - Split mode: low byte uses timer0 controls.
// - Split high byte: internal clock, timer1 run.
// - Split high overflow sets timer1 flag.
// - Timer1 during split: no pin, no flag.
// - Timer1 mode 3 stops it.
`ifndef DCTM_CFG_SVH
`define DCTM_CFG_SVH

`define DCTM_OFS_CTRL   8'h00
`define DCTM_OFS_MODE   8'h04
`define DCTM_OFS_CKSEL  8'h08
`define DCTM_OFS_IRQCF  8'h0c
`define DCTM_OFS_IE     8'h10
`define DCTM_OFS_T0LO   8'h14
`define DCTM_OFS_T0HI   8'h18
`define DCTM_OFS_T1LO   8'h1c
`define DCTM_OFS_T1HI   8'h20

`define DCTM_RESET_VAL  8'h00

`define DCTM_TF1        7
`define DCTM_TR1        6
`define DCTM_TF0        5
`define DCTM_TR0        4
`define DCTM_GATE1      7
`define DCTM_CT1        6
`define DCTM_MODE1_LSB  4
`define DCTM_TIMER0_GATE_ENABLE      3
`define DCTM_CT0        2
`define DCTM_MODE0_LSB  0
`define DCTM_T1SYS      4
`define DCTM_T0SYS      3
`define DCTM_SCA_LSB    0
`define DCTM_POL_B      7
`define DCTM_POL_A      3
`define DCTM_ET1        3
`define DCTM_ET0        1

`define DCTM_DIV_SCA0   8'h0c
`define DCTM_DIV_SCA1   8'h04
`define DCTM_DIV_SCA2   8'h30
`define DCTM_DIV_SCA3   8'h08

`endif

// ===== pkg/dctm_pkg.sv
`default_nettype none
package dctm_pkg;

   typedef enum logic [1:0] {
      DCTM_MODE_13BIT,
      DCTM_MODE_16BIT,
      DCTM_MODE_RELOAD,
      DCTM_MODE_SPLIT
   } dctm_mode_t;

   typedef struct packed {
      logic [7:0]      ctrl;
      logic [7:0]      mode;
      logic [7:0]      cksel;
      logic [7:0]      irqcf;
      logic [7:0]      ie;
      logic [7:0]      t0lo;
      logic [7:0]      t0hi;
      logic [7:0]      t1lo;
      logic [7:0]      t1hi;
      logic [2:0]      sync_ev0;
      logic [2:0]      sync_ev1;
      logic [1:0]      sync_ga;
      logic [1:0]      sync_gb;
      logic [3:0][7:0] pcnt;
      logic            ack;
      logic [7:0]      rdat;
      logic            t1_ovf;
   } dctm_state_t;

endpackage
`default_nettype wire

// ===== rtl/dctm_top.sv
// The Wishbone register port and the register offsets were decided locally.
`include "dctm_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module dctm_top
   import dctm_pkg::*;
#(
   parameter logic [3:0][7:0] PRESCALE_DIVS = {`DCTM_DIV_SCA3, `DCTM_DIV_SCA2,
                                               `DCTM_DIV_SCA1, `DCTM_DIV_SCA0}
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        timer0_event_pin_i,
   input  wire logic        timer1_event_pin_i,
   input  wire logic        ext_irq_input_a_i,
   input  wire logic        ext_irq_input_b_i,
   input  wire logic        timer0_irq_ack_i,
   input  wire logic        timer1_irq_ack_i,
   output logic             timer0_irq_o,
   output logic             timer1_irq_o,
   output logic             timer1_overflow_o
);

   // A divisor of zero would wrap and tick once every 256 cycles.
   generate
      for (genvar g = 0; g < 4; g++) begin : g_chk
         if (PRESCALE_DIVS[g] == 8'h00) begin : g_bad
            $error("Prescale divisor must be non-zero.");
         end
      end
   endgenerate

   dctm_state_t q;
   dctm_state_t next_q;

   // Returns {overflow, high, low} after one count step.
   function automatic logic [16:0] dctm_step(input dctm_mode_t m,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
      logic [12:0] c13;
      logic [15:0] c16;
      logic [16:0] r;
      c13 = {hi, lo[4:0]};
      c16 = {hi, lo};
      r = {1'b0, hi, lo};
      case (m)
         DCTM_MODE_13BIT: begin
            c13 = c13 + 13'h0001;
            r = {(c13 == 13'h0000), c13[12:5], lo[7:5], c13[4:0]};
         end
         // The count is not latched, so a two-byte read may straddle a carry.
         // Full sixteen bits.
         DCTM_MODE_16BIT: begin
            c16 = c16 + 16'h0001;
            r = {(c16 == 16'h0000), c16};
         end
         DCTM_MODE_RELOAD: begin
            if (lo == 8'hff) begin
               r = {1'b1, hi, hi};
            end else begin
               r = {1'b0, hi, lo + 8'h01};
            end
         end
         // Low byte as eight bit counter.
         DCTM_MODE_SPLIT: begin
            r = {(lo == 8'hff), hi, lo + 8'h01};
         end
         default: begin
            r = {1'b0, hi, lo};
         end
      endcase
      return r;
   endfunction

   // Decodes a byte address into a register write hit.
   function automatic logic dctm_hit(input logic [7:0] adr,
                                     input logic [7:0] ofs);
      return adr == ofs;
   endfunction

   // Picks the prescaled tick named by the clock-scale field.
   function automatic logic dctm_pre_pick(input logic [3:0] ticks,
                                          input logic [1:0] sel);
      return ticks[sel];
   endfunction

   // Internal count clock: system clock or the selected prescaled tick.
   function automatic logic dctm_int_tick(input logic sys_sel,
                                          input logic pre);
      return sys_sel | pre;
   endfunction

   // A gating input is active when its level matches its polarity bit.
   function automatic logic dctm_gate_on(input logic lvl,
                                         input logic pol);
      return lvl == pol;
   endfunction

   // Run bit, qualified by the gate input when gating is enabled.
   function automatic logic dctm_run(input logic tr,
                                     input logic gate_en,
                                     input logic gate_ok);
      return tr & (~gate_en | gate_ok);
   endfunction

   // Read mux; unmapped addresses read as zero.
   function automatic logic [7:0] dctm_rd_reg(input dctm_state_t s,
                                              input logic [7:0]  adr);
      logic [7:0] v;
      case (adr)
         `DCTM_OFS_CTRL:  v = s.ctrl;
         `DCTM_OFS_MODE:  v = s.mode;
         `DCTM_OFS_CKSEL: v = s.cksel;
         `DCTM_OFS_IRQCF: v = s.irqcf;
         `DCTM_OFS_IE:    v = s.ie;
         `DCTM_OFS_T0LO:  v = s.t0lo;
         `DCTM_OFS_T0HI:  v = s.t0hi;
         `DCTM_OFS_T1LO:  v = s.t1lo;
         `DCTM_OFS_T1HI:  v = s.t1hi;
         default:         v = 8'h00;
      endcase
      return v;
   endfunction

   dctm_mode_t mode0;
   dctm_mode_t mode1;
   logic       split;
   logic [3:0] pre_tick;
   logic       pre_sel;

   logic       fall0;
   logic       fall1;
   logic       gate_a;
   logic       gate_b;
   logic       run0;
   logic       run1;
   logic       run0h;
   logic       tick0;
   logic       tick1;
   logic       tick0h;

   logic       req;
   logic       wr;
   logic [7:0] wbyte;

   logic [16:0] st0;
   logic [16:0] st1;
   logic [7:0]  t0hi_inc;
   logic        set_tf0;
   logic        set_tf1;
   logic        ovf1;

   always_comb begin
      next_q = q;

      // Two-stage synchronisers; the event pins add a history stage.
      next_q.sync_ev0 = {q.sync_ev0[1:0], timer0_event_pin_i};
      next_q.sync_ev1 = {q.sync_ev1[1:0], timer1_event_pin_i};
      next_q.sync_ga  = {q.sync_ga[0], ext_irq_input_a_i};
      next_q.sync_gb  = {q.sync_gb[0], ext_irq_input_b_i};
      // Falling edge gives one count pulse.
      fall0 = q.sync_ev0[2] & ~q.sync_ev0[1];
      fall1 = q.sync_ev1[2] & ~q.sync_ev1[1];

      // Four prescaled ticks from free-running dividers.
      for (int k = 0; k < 4; k++) begin
         pre_tick[k] = (q.pcnt[k] == PRESCALE_DIVS[k] - 8'h01);
         next_q.pcnt[k] = pre_tick[k] ? 8'h00 : q.pcnt[k] + 8'h01;
      end
      pre_sel = dctm_pre_pick(pre_tick, q.cksel[`DCTM_SCA_LSB +: 2]);

      mode0 = dctm_mode_t'(q.mode[`DCTM_MODE0_LSB +: 2]);
      mode1 = dctm_mode_t'(q.mode[`DCTM_MODE1_LSB +: 2]);
      split = (mode0 == DCTM_MODE_SPLIT);

      // Gate level compared with polarity bit.
      gate_a = dctm_gate_on(q.sync_ga[1], q.irqcf[`DCTM_POL_A]);
      gate_b = dctm_gate_on(q.sync_gb[1], q.irqcf[`DCTM_POL_B]);

      run0 = dctm_run(q.ctrl[`DCTM_TR0], q.mode[`DCTM_TIMER0_GATE_ENABLE], gate_a);
      // Mode 3 halts timer1; in split its mode is its run.
      if (mode1 == DCTM_MODE_SPLIT) begin
         run1 = 1'b0;
      end else if (split) begin
         run1 = 1'b1;
      end else begin
         run1 = dctm_run(q.ctrl[`DCTM_TR1], q.mode[`DCTM_GATE1], gate_b);
      end
      // Split high byte runs from timer1 run bit.
      run0h = split & q.ctrl[`DCTM_TR1];

      if (q.mode[`DCTM_CT0]) begin
         tick0 = fall0;
      end else begin
         tick0 = dctm_int_tick(q.cksel[`DCTM_T0SYS], pre_sel);
      end
      // Timer1 takes no pin clock during split.
      if (q.mode[`DCTM_CT1] & ~split) begin
         tick1 = fall1;
      end else begin
         tick1 = dctm_int_tick(q.cksel[`DCTM_T1SYS], pre_sel);
      end
      // Split high byte never takes the event pin.
      tick0h = dctm_int_tick(q.cksel[`DCTM_T0SYS], pre_sel);

      st0 = dctm_step(mode0, q.t0lo, q.t0hi);
      st1 = dctm_step(mode1, q.t1lo, q.t1hi);
      t0hi_inc = q.t0hi + 8'h01;
      set_tf0 = 1'b0;
      set_tf1 = 1'b0;
      ovf1 = 1'b0;

      if (run0 & tick0) begin
         next_q.t0lo = st0[7:0];
         if (!split) begin
            next_q.t0hi = st0[15:8];
         end
         set_tf0 = st0[16];
      end
      if (run0h & tick0h) begin
         next_q.t0hi = t0hi_inc;
         set_tf1 = (q.t0hi == 8'hff);
      end
      if (run1 & tick1) begin
         next_q.t1lo = st1[7:0];
         next_q.t1hi = st1[15:8];
         ovf1 = st1[16];
         // Timer1 sets no flag of its own while timer0 is split.
         if (!split) begin
            set_tf1 = st1[16];
         end
      end
      next_q.t1_ovf = ovf1;

      // Wishbone classic: ack one cycle after the request, for one cycle.
      // Ack gates itself, so a strobe held through ack is answered every second cycle.
      req = wb_cyc_i & wb_stb_i;
      wr = req & wb_we_i & q.ack & wb_sel_i[0];
      wbyte = wb_dat_i[7:0];
      next_q.ack = req & ~q.ack;
      if (req & ~q.ack) begin
         next_q.rdat = dctm_rd_reg(q, wb_adr_i);
      end

      // Writing the run bit leaves the count alone.
      if (wr && dctm_hit(wb_adr_i, `DCTM_OFS_CTRL)) begin
         next_q.ctrl = wbyte;
      end
      if (wr && dctm_hit(wb_adr_i, `DCTM_OFS_MODE)) begin
         next_q.mode = wbyte;
      end
      if (wr && dctm_hit(wb_adr_i, `DCTM_OFS_CKSEL)) begin
         next_q.cksel = wbyte;
      end
      if (wr && dctm_hit(wb_adr_i, `DCTM_OFS_IRQCF)) begin
         next_q.irqcf = wbyte;
      end
      if (wr && dctm_hit(wb_adr_i, `DCTM_OFS_IE)) begin
         next_q.ie = wbyte;
      end
      // Software loads count bytes; its write beats a count.
      if (wr && dctm_hit(wb_adr_i, `DCTM_OFS_T0LO)) begin
         next_q.t0lo = wbyte;
      end
      if (wr && dctm_hit(wb_adr_i, `DCTM_OFS_T0HI)) begin
         next_q.t0hi = wbyte;
      end
      if (wr && dctm_hit(wb_adr_i, `DCTM_OFS_T1LO)) begin
         next_q.t1lo = wbyte;
      end
      if (wr && dctm_hit(wb_adr_i, `DCTM_OFS_T1HI)) begin
         next_q.t1hi = wbyte;
      end

      // Acknowledge clears, but a new overflow wins.
      if (timer0_irq_ack_i) begin
         next_q.ctrl[`DCTM_TF0] = 1'b0;
      end
      if (timer1_irq_ack_i) begin
         next_q.ctrl[`DCTM_TF1] = 1'b0;
      end
      if (set_tf0) begin
         next_q.ctrl[`DCTM_TF0] = 1'b1;
      end
      if (set_tf1) begin
         next_q.ctrl[`DCTM_TF1] = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q.ctrl     <= `DCTM_RESET_VAL;
         q.mode     <= `DCTM_RESET_VAL;
         q.cksel    <= `DCTM_RESET_VAL;
         q.irqcf    <= `DCTM_RESET_VAL;
         q.ie       <= `DCTM_RESET_VAL;
         q.t0lo     <= `DCTM_RESET_VAL;
         q.t0hi     <= `DCTM_RESET_VAL;
         q.t1lo     <= `DCTM_RESET_VAL;
         q.t1hi     <= `DCTM_RESET_VAL;
         // A low history stage after reset cannot fake a falling edge.
         q.sync_ev0 <= 3'h0;
         q.sync_ev1 <= 3'h0;
         q.sync_ga  <= 2'h0;
         q.sync_gb  <= 2'h0;
         q.pcnt     <= '0;
         q.ack      <= 1'b0;
         q.rdat     <= 8'h00;
         q.t1_ovf   <= 1'b0;
      end else begin
         q <= next_q;
      end
   end

   assign timer0_irq_o = q.ctrl[`DCTM_TF0] & q.ie[`DCTM_ET0];
   assign timer1_irq_o = q.ctrl[`DCTM_TF1] & q.ie[`DCTM_ET1];
   // Timer1 overflow stays visible for baud and conversion use in split.
   assign timer1_overflow_o = q.t1_ovf;
   assign wb_ack_o = q.ack;
   assign wb_dat_o = {24'h000000, q.rdat};

endmodule
`default_nettype wire

// ===== verif/dctm_checker.sv
`timescale 1ns/1ns
`default_nettype none
module dctm_checker (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        timer0_irq_ack_i,
   input wire logic        timer1_irq_ack_i,
   input wire logic        timer0_irq_o,
   input wire logic        timer1_irq_o,
   input wire logic        timer1_overflow_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held past one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack rose without prior request");
   a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read lanes not zero");
   a_rst_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && !timer0_irq_o && !timer1_irq_o)
      else $error("outputs active after reset");
   // The flag may drop only after an acknowledge pulse or a bus write.
   a_irq0_clear: assert property ($fell(timer0_irq_o) |-> $past(timer0_irq_ack_i) || $past(wb_ack_o) ||
      $past(timer0_irq_ack_i, 2) || $past(wb_ack_o, 2))
      else $error("timer0 request dropped without clear");
   a_irq1_clear: assert property ($fell(timer1_irq_o) |-> $past(timer1_irq_ack_i) || $past(wb_ack_o) ||
      $past(timer1_irq_ack_i, 2) || $past(wb_ack_o, 2))
      else $error("timer1 request dropped without clear");

   c_irq0: cover property ($rose(timer0_irq_o));
   c_irq1: cover property ($rose(timer1_irq_o));
   c_ovf1: cover property (timer1_overflow_o);
endmodule
bind dctm_top dctm_checker u_chk (.*);
`default_nettype wire

// ===== verif/dctm_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
module dctm_pins_model (
   input wire logic       clk_i,
   input wire logic [1:0] ev_req_i,
   output logic     [1:0] ev_pin_o
);
   logic [1:0][2:0] hold = '0;
   // levels of at least two cycles
   // Each event is a four-cycle low; the caller keeps the high phase at least as long.
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 2; i++) begin
         if (ev_req_i[i])
            hold[i] <= 3'h4;
         else if (hold[i] != 3'h0)
            hold[i] <= hold[i] - 3'h1;
      end
   end
   assign ev_pin_o[0] = (hold[0] == 3'h0);
   assign ev_pin_o[1] = (hold[1] == 3'h0);
endmodule
`default_nettype wire

// ===== verif/test_dual_counter_timer_modes.sv
`timescale 1ns/1ns
`default_nettype none
module test_dual_counter_timer_modes;
   logic        clk_i      = 1'b0;
   logic        rst_i      = 1'b1;
   logic        cyc        = 1'b0;
   logic        we         = 1'b0;
   logic [7:0]  adr        = 8'h00;
   logic [31:0] wdat       = 32'h0;
   logic [31:0] rdat;
   logic        ack;
   logic [1:0]  ev_req     = 2'b00;
   logic [1:0]  ev_pin;
   logic [1:0]  gate       = 2'b00;
   logic [1:0]  irq_ack    = 2'b00;
   logic [1:0]  irq;
   logic        ovf;
   logic [7:0]  q;
   int          mismatches = 0;
   int          num_checks = 0;
   logic        seen_ovf   = 1'b0;

   dctm_top #(.PRESCALE_DIVS({8'h02, 8'h02, 8'h02, 8'h02})) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .timer0_event_pin_i(ev_pin[0]), .timer1_event_pin_i(ev_pin[1]),
      .ext_irq_input_a_i(gate[0]), .ext_irq_input_b_i(gate[1]),
      .timer0_irq_ack_i(irq_ack[0]), .timer1_irq_ack_i(irq_ack[1]),
      .timer0_irq_o(irq[0]), .timer1_irq_o(irq[1]), .timer1_overflow_o(ovf));
   dctm_pins_model pins (.clk_i(clk_i), .ev_req_i(ev_req), .ev_pin_o(ev_pin));

   initial forever #4 clk_i = ~clk_i;

   // The overflow output is a one-cycle pulse, so it is caught in a sticky bit.
   always @(posedge clk_i) begin
      if (ovf === 1'b1) begin
         seen_ovf <= 1'b1;
      end
   end

   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h want %h", $time, s, e);
      end
   endtask

   // Read data is taken at the same edge that samples ack high.
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat[7:0];
      cyc <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         give_verdict();
      end
      @(posedge clk_i);
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask

   task rd(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, e);
   endtask

   // Each event leaves the pin high long enough for the count to land.
   task ev(input int i, input int k);
      repeat (k) begin
         ev_req[i] <= 1'b1;
         @(posedge clk_i);
         ev_req[i] <= 1'b0;
         repeat (9) @(posedge clk_i);
      end
   endtask

   task wirq(input int i);
      int n;
      n = 0;
      while (irq[i] !== 1'b1 && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
      chk({7'h0, irq[i]}, 8'h01);
      if (n >= 2000)
         give_verdict();
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wr(8'h10, 8'h0a);
      wr(8'h20, 8'hfe);
      wr(8'h1c, 8'hfe);
      wr(8'h04, 8'h60);
      wr(8'h00, 8'h40);
      ev(1, 2);
      rd(8'h1c, 8'hfe);
      rd(8'h20, 8'hfe);
      rd(8'h00, 8'hc0);
      wirq(1);
      chk({7'h0, seen_ovf}, 8'h01);
      irq_ack[1] <= 1'b1;
      @(posedge clk_i);
      irq_ack[1] <= 1'b0;
      rd(8'h00, 8'h40);
      wr(8'h00, 8'h00);
      wr(8'h18, 8'hff);
      wr(8'h14, 8'h1f);
      wr(8'h0c, 8'h08);
      wr(8'h04, 8'h0c);
      wr(8'h00, 8'h10);
      ev(0, 1);
      rd(8'h14, 8'h1f);
      gate[0] <= 1'b1;
      ev(0, 1);
      rd(8'h18, 8'h00);
      rd(8'h14, 8'h00);
      wirq(0);
      rd(8'h00, 8'h30);
      wr(8'h0c, 8'h00);
      ev(0, 1);
      rd(8'h14, 8'h00);
      wr(8'h00, 8'h00);
      wr(8'h1c, 8'h12);
      wr(8'h14, 8'hff);
      wr(8'h18, 8'h00);
      wr(8'h04, 8'h37);
      wr(8'h08, 8'h08);
      wr(8'h00, 8'h10);
      ev(0, 1);
      rd(8'h14, 8'h00);
      rd(8'h18, 8'h00);
      rd(8'h00, 8'h30);
      wr(8'h00, 8'h50);
      wirq(1);
      rd(8'h1c, 8'h12);
      give_verdict();
   end
endmodule
`default_nettype wire
